// >>> src/vpdrb_defs.svh
`ifndef VPDRB_DEFS_SVH
`define VPDRB_DEFS_SVH

// ==================== Register offsets ====================
`define VPDRB_ADDR_UNIT 8'h00
`define VPDRB_ADDR_TEXT 8'h04
`define VPDRB_ADDR_ID   8'h08
`define VPDRB_ADDR_TMEM 8'h0c
`define VPDRB_ADDR_IMEM 8'h10
`define VPDRB_ADDR_STAT 8'h14
`define VPDRB_ADDR_FRU  8'h18

// ==================== Reset values ====================
`define VPDRB_RST_UNIT  8'h00
`define VPDRB_RST_TPAGE 7'h01
`define VPDRB_RST_LEN   8'h00

// ==================== Field positions ====================
`define VPDRB_STAT_TEXT 0
`define VPDRB_STAT_DESC 1
`define VPDRB_STAT_REF  2
`define VPDRB_STAT_NAME 3
`define VPDRB_STAT_VIRT 4
`define VPDRB_STAT_BUSY 5
`define VPDRB_MIDX_LSB  8

// ==================== Page layout ====================
`define VPDRB_PG_ID     8'h83
`define VPDRB_PG_TMIN   8'h01
`define VPDRB_PG_TMAX   8'h7f
`define VPDRB_TXT_HDR   10'd5
`define VPDRB_ID_HDR    10'd4
`define VPDRB_GRAPH_LO  8'h20
`define VPDRB_GRAPH_HI  8'h7e
`define VPDRB_NUL       8'h00
`define VPDRB_CS_BIN    4'h1
`define VPDRB_CS_TXT    4'h2
`define VPDRB_AS_MAX    2'h2
`define VPDRB_AS_TGT    2'h2
`define VPDRB_IDT_REGX  4'h3
`define VPDRB_NAA_REGX  4'h6
`endif

// >>> src/vpdrb_fifo.sv
`timescale 1ns/1ns
module vpdrb_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         reset,
    // Fill side.
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // Drain side, held in an output register.
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          ov_q, ov_d;
    logic [W-1:0]  od_q, od_d;
    logic          push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = ov_q;
    assign out_data  = od_q;

    always_comb begin
        push = in_valid && in_ready;
        pop  = (!ov_q || out_ready) && (cnt_q != '0);
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
        od_d = pop ? mem_q[rd_q] : od_q;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            ov_q  <= 1'b0;
            od_q  <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            ov_q  <= ov_d;
            od_q  <= od_d;
        end
    end

    // Storage has no reset; nothing reads a slot before it is written.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule // vpdrb_fifo

// >>> src/vpdrb_pkg.sv
package vpdrb_pkg;
    typedef struct packed {
        logic [7:0]  page;
        logic [15:0] host_buffer_limit;
    } vpdrb_req_t;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } vpdrb_byte_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_DONE = 3'b100
    } vpdrb_state_t;
endpackage

// >>> src/vpdrb_top.sv
`timescale 1ns/1ns
`include "vpdrb_defs.svh"
module vpdrb_top #(
    parameter int TEXT_DEPTH = 64,
    parameter int ID_DEPTH   = 64,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               reset,
    // Register port.
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    // Page request.
    input  wire logic               req_valid,
    input  wire vpdrb_pkg::vpdrb_req_t req,
    output logic                    req_ready,
    // Page byte stream.
    output logic                    out_valid,
    output vpdrb_pkg::vpdrb_byte_t  out_byte,
    input  wire logic               out_ready,
    output logic                    done
);
    import vpdrb_pkg::*;

    localparam int TAW = $clog2(TEXT_DEPTH);
    localparam int IAW = $clog2(ID_DEPTH);

    // ==================== Register file ====================
    logic [7:0]  unit_q, unit_d, tlen_q, tlen_d, vlen_q, vlen_d, dlen_q, dlen_d;
    logic [7:0]  fru_q, fru_d;
    logic [6:0]  tpage_q, tpage_d;
    logic [3:0]  names_q, names_d;
    logic        virt_q, virt_d;
    logic [4:0]  stat_q, stat_d, stat_set;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0]  tmem_q [TEXT_DEPTH];
    logic [7:0]  imem_q [ID_DEPTH];
    logic        fru_has_page;

    // ==================== Transfer state ====================
    vpdrb_state_t state_q, state_d;
    logic [7:0]  page_q, page_d, pos_q, pos_d, dl_q, dl_d, byte_c;
    logic        txt_q, txt_d, served_q, served_d, first_q, first_d;
    logic [9:0]  idx_q, idx_d, total_q, total_d, plen;
    logic [15:0] cnt_q, cnt_d;
    logic [3:0]  nseen_q, nseen_d;
    logic        rdy_q, done_q;
    logic        push, fire, last_c, fifo_in_ready, is_txt, is_id, desc_end;
    logic [9:0]  new_total;
    logic [TAW-1:0] tidx;
    logic [IAW-1:0] iidx;

    assign reg_rdata = rdata_q;
    assign req_ready = rdy_q;
    assign done      = done_q;

    assign fru_has_page = (fru_q >= `VPDRB_PG_TMIN) && (fru_q <= `VPDRB_PG_TMAX);

    always_comb begin
        unit_d  = unit_q;
        virt_d  = virt_q;
        tpage_d = tpage_q;
        tlen_d  = tlen_q;
        vlen_d  = vlen_q;
        dlen_d  = dlen_q;
        names_d = names_q;
        fru_d   = fru_q;
        stat_d  = stat_q;
        rdata_d = 32'h0000_0000;
        if (reg_wr) begin
            unique case (reg_addr)
                `VPDRB_ADDR_UNIT: begin
                    unit_d = reg_wdata[7:0];
                    virt_d = reg_wdata[8];
                end
                `VPDRB_ADDR_TEXT: begin
                    tpage_d = reg_wdata[6:0];
                    tlen_d  = reg_wdata[15:8];
                    vlen_d  = reg_wdata[23:16];
                end
                `VPDRB_ADDR_ID: begin
                    dlen_d  = reg_wdata[7:0];
                    names_d = reg_wdata[11:8];
                end
                `VPDRB_ADDR_STAT: stat_d = stat_q & ~reg_wdata[4:0];
                `VPDRB_ADDR_FRU:  fru_d = reg_wdata[7:0];
                default: ;
            endcase
        end
        // A fault raised in the cycle software clears it still sticks.
        stat_d = stat_d | stat_set;
        if (reg_rd) begin
            unique case (reg_addr)
                `VPDRB_ADDR_UNIT: rdata_d = {23'h0, virt_q, unit_q};
                `VPDRB_ADDR_TEXT: rdata_d = {8'h00, vlen_q, tlen_q, 1'b0, tpage_q};
                `VPDRB_ADDR_ID:   rdata_d = {20'h0, names_q, dlen_q};
                `VPDRB_ADDR_STAT: rdata_d = {26'h0, !rdy_q, stat_q};
                `VPDRB_ADDR_FRU:  rdata_d = {23'h0, fru_has_page, fru_q};
                default:          rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            unit_q  <= `VPDRB_RST_UNIT;
            virt_q  <= 1'b0;
            tpage_q <= `VPDRB_RST_TPAGE;
            tlen_q  <= `VPDRB_RST_LEN;
            vlen_q  <= `VPDRB_RST_LEN;
            dlen_q  <= `VPDRB_RST_LEN;
            names_q <= 4'h0;
            fru_q   <= 8'h00;
            stat_q  <= 5'h00;
            rdata_q <= 32'h0000_0000;
        end else begin
            unit_q  <= unit_d;
            virt_q  <= virt_d;
            tpage_q <= tpage_d;
            tlen_q  <= tlen_d;
            vlen_q  <= vlen_d;
            dlen_q  <= dlen_d;
            names_q <= names_d;
            fru_q   <= fru_d;
            stat_q  <= stat_d;
            rdata_q <= rdata_d;
        end
    end

    // Descriptors come only from software writes, so they name the unit, never the media.
    always_ff @(posedge clk) begin
        if (reg_wr && reg_addr == `VPDRB_ADDR_TMEM) begin
            tmem_q[reg_wdata[`VPDRB_MIDX_LSB +: TAW]] <= reg_wdata[7:0];
        end
        if (reg_wr && reg_addr == `VPDRB_ADDR_IMEM) begin
            imem_q[reg_wdata[`VPDRB_MIDX_LSB +: IAW]] <= reg_wdata[7:0];
        end
    end

    // ==================== Page byte builder ====================
    assign plen = total_q - `VPDRB_ID_HDR;

    always_comb begin
        tidx   = TAW'(idx_q - `VPDRB_TXT_HDR);
        iidx   = IAW'(idx_q - `VPDRB_ID_HDR);
        byte_c = 8'h00;
        if (idx_q == 10'd0) begin
            byte_c = unit_q;
        end else if (txt_q) begin
            if (idx_q == 10'd1) begin
                byte_c = page_q;
            end else if (idx_q == 10'd3) begin
                byte_c = plen[7:0];
            end else if (idx_q == 10'd4) begin
                byte_c = served_q ? tlen_q : 8'h00;
            end else if (idx_q >= `VPDRB_TXT_HDR) begin
                byte_c = tmem_q[tidx];
            end
        end else begin
            if (idx_q == 10'd1) begin
                byte_c = `VPDRB_PG_ID;
            end else if (idx_q == 10'd2) begin
                byte_c = {6'h00, plen[9:8]};
            end else if (idx_q == 10'd3) begin
                byte_c = plen[7:0];
            end else begin
                byte_c = imem_q[iidx];
            end
        end
    end

    // ==================== Transfer control ====================
    always_comb begin
        state_d   = state_q;
        page_d    = page_q;
        txt_d     = txt_q;
        served_d  = served_q;
        idx_d     = idx_q;
        total_d   = total_q;
        cnt_d     = cnt_q;
        pos_d     = pos_q;
        dl_d      = dl_q;
        first_d   = first_q;
        nseen_d   = nseen_q;
        stat_set  = 5'h00;
        is_txt    = (req.page >= `VPDRB_PG_TMIN) && (req.page <= `VPDRB_PG_TMAX);
        is_id     = (req.page == `VPDRB_PG_ID);
        new_total = `VPDRB_ID_HDR + 10'(dlen_q);
        push      = (state_q == ST_SEND);
        fire      = push && fifo_in_ready;
        last_c    = ({6'h00, idx_q} == cnt_q - 16'd1);
        desc_end  = 1'b0;
        if (is_txt) begin
            new_total = `VPDRB_TXT_HDR;
            if (req.page[6:0] == tpage_q && tlen_q != 8'h00) begin
                new_total = `VPDRB_TXT_HDR + 10'(tlen_q) + 10'(vlen_q);
            end
        end
        unique case (state_q)
            ST_IDLE: begin
                if (req_valid) begin
                    page_d   = req.page;
                    txt_d    = is_txt;
                    served_d = is_txt && req.page[6:0] == tpage_q && tlen_q != 8'h00;
                    total_d  = new_total;
                    idx_d    = 10'd0;
                    pos_d    = 8'h00;
                    first_d  = 1'b1;
                    nseen_d  = 4'h0;
                    // Stop at the host limit or the page end, whichever is first.
                    cnt_d = (req.host_buffer_limit < {6'h00, new_total}) ?
                            req.host_buffer_limit : {6'h00, new_total};
                    stat_set[`VPDRB_STAT_REF] = !(is_txt || is_id);
                    state_d = ((is_txt || is_id) && req.host_buffer_limit != 16'h0000) ?
                              ST_SEND : ST_DONE;
                end
            end
            ST_SEND: begin
                if (fire) begin
                    idx_d = idx_q + 10'd1;
                    if (last_c) begin
                        state_d = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                // Only names that were actually sent can be counted here.
                stat_set[`VPDRB_STAT_NAME] = !txt_q && nseen_q != 4'h0 &&
                                             nseen_q != names_q;
                state_d = ST_IDLE;
            end
        endcase
        if (fire && txt_q && served_q && idx_q >= `VPDRB_TXT_HDR &&
            idx_q < `VPDRB_TXT_HDR + 10'(tlen_q)) begin
            if (!((byte_c >= `VPDRB_GRAPH_LO && byte_c <= `VPDRB_GRAPH_HI) ||
                  byte_c == `VPDRB_NUL)) begin
                stat_set[`VPDRB_STAT_TEXT] = 1'b1;
            end
            if (idx_q == `VPDRB_ID_HDR + 10'(tlen_q) && byte_c != `VPDRB_NUL) begin
                stat_set[`VPDRB_STAT_TEXT] = 1'b1;
            end
        end
        if (fire && !txt_q && idx_q >= `VPDRB_ID_HDR) begin
            pos_d = pos_q + 8'h01;
            if (pos_q == 8'h00 && byte_c[3:0] != `VPDRB_CS_BIN &&
                byte_c[3:0] != `VPDRB_CS_TXT) begin
                stat_set[`VPDRB_STAT_DESC] = 1'b1;
            end
            if (pos_q == 8'h01) begin
                stat_set[`VPDRB_STAT_DESC] = stat_set[`VPDRB_STAT_DESC] ||
                                             byte_c[5:4] > `VPDRB_AS_MAX;
                nseen_d = nseen_q + 4'(byte_c[5:4] == `VPDRB_AS_TGT);
                stat_set[`VPDRB_STAT_VIRT] = first_q && virt_q &&
                                             byte_c[3:0] != `VPDRB_IDT_REGX;
            end
            if (pos_q == 8'h03) begin
                dl_d     = byte_c;
                desc_end = (byte_c == 8'h00);
            end
            if (pos_q == 8'h04 && first_q && virt_q && byte_c[7:4] != `VPDRB_NAA_REGX) begin
                stat_set[`VPDRB_STAT_VIRT] = 1'b1;
            end
            if (pos_q > 8'h03 && {1'b0, pos_q} == {1'b0, dl_q} + 9'd3) begin
                desc_end = 1'b1;
            end
            if (desc_end) begin
                pos_d   = 8'h00;
                first_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q  <= ST_IDLE;
            page_q   <= 8'h00;
            txt_q    <= 1'b0;
            served_q <= 1'b0;
            idx_q    <= 10'd0;
            total_q  <= 10'd0;
            cnt_q    <= 16'h0000;
            pos_q    <= 8'h00;
            dl_q     <= 8'h00;
            first_q  <= 1'b1;
            nseen_q  <= 4'h0;
            rdy_q    <= 1'b1;
            done_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            page_q   <= page_d;
            txt_q    <= txt_d;
            served_q <= served_d;
            idx_q    <= idx_d;
            total_q  <= total_d;
            cnt_q    <= cnt_d;
            pos_q    <= pos_d;
            dl_q     <= dl_d;
            first_q  <= first_d;
            nseen_q  <= nseen_d;
            rdy_q    <= (state_d == ST_IDLE);
            done_q   <= (state_d == ST_DONE);
        end
    end

    // A stalled drain side fills the buffer and then holds the builder in place.
    vpdrb_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (push),
        .in_data   ({last_c, byte_c}),
        .in_ready  (fifo_in_ready),
        .out_valid (out_valid),
        .out_data  (out_byte),
        .out_ready (out_ready)
    );

    // ==================== Checks ====================
    a_text_code_echo: assert property (@(posedge clk) disable iff (reset)
        fire && txt_q && idx_q == 10'd1 |-> byte_c == page_q && page_q <= `VPDRB_PG_TMAX)
        else $error("text page code does not echo the request");
    a_text_plen_full: assert property (@(posedge clk) disable iff (reset)
        fire && txt_q && idx_q == 10'd3 |->
        byte_c == (served_q ? 8'(tlen_q + vlen_q + 8'd1) : 8'h01))
        else $error("text page length is wrong");
    a_text_len_full: assert property (@(posedge clk) disable iff (reset)
        fire && txt_q && served_q && idx_q == 10'd4 |-> byte_c == tlen_q)
        else $error("text length field is wrong");
    a_text_len_zero: assert property (@(posedge clk) disable iff (reset)
        fire && txt_q && !served_q && idx_q == 10'd4 |-> byte_c == 8'h00)
        else $error("missing text must report zero length");
    a_text_bad_flag: assert property (@(posedge clk) disable iff (reset)
        fire && txt_q && served_q && idx_q >= `VPDRB_TXT_HDR &&
        idx_q < `VPDRB_TXT_HDR + 10'(tlen_q) && byte_c > `VPDRB_GRAPH_HI
        |=> stat_q[`VPDRB_STAT_TEXT])
        else $error("bad text byte not flagged");
    a_id_page_code: assert property (@(posedge clk) disable iff (reset)
        fire && !txt_q && idx_q == 10'd1 |-> byte_c == 8'h83)
        else $error("identification page code is not 83h");
    a_id_len_order: assert property (@(posedge clk) disable iff (reset)
        fire && !txt_q && idx_q == 10'd2 && !last_c |=> ##[0:40] fire ##0 byte_c == dlen_q)
        else $error("identification length bytes out of order");
    a_send_bound: assert property (@(posedge clk) disable iff (reset)
        state_q == ST_SEND |-> {6'h00, idx_q} < cnt_q && cnt_q <= {6'h00, total_q})
        else $error("transfer runs past its limit");
    a_desc_cs_flag: assert property (@(posedge clk) disable iff (reset)
        fire && !txt_q && idx_q >= `VPDRB_ID_HDR && pos_q == 8'h00 && byte_c[3:0] == 4'h0
        |=> stat_q[`VPDRB_STAT_DESC])
        else $error("reserved code set not flagged");
endmodule // vpdrb_top

// >>> tb/vpd_page_response_builder_tb.sv
`timescale 1ns/1ns
`include "vpdrb_defs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module vpd_page_response_builder_tb;
    import vpdrb_pkg::*;
    typedef logic [7:0] vpdrb_bq_t[$];
    logic        clk;
    logic        reset;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        req_valid;
    vpdrb_req_t  req;
    logic        req_ready;
    logic        out_valid;
    vpdrb_byte_t out_byte;
    logic        out_ready;
    logic        done;
    int          fails;
    int          n_checks;
    vpdrb_bq_t   none;

    vpdrb_top uut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .out_valid(out_valid), .out_byte(out_byte),
        .out_ready(out_ready), .done(done));
    vpdrb_host host (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .out_valid(out_valid), .out_byte(out_byte),
        .out_ready(out_ready), .done(done));

    // ========================================
    // Bus and stream helpers
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic load(input logic [7:0] a, input vpdrb_bq_t b);
        foreach (b[i]) wr(a, {18'h0, 6'(i), b[i]});
    endtask
    task automatic page(input logic [7:0] pg, input logic [15:0] lim, input int stall,
                        input vpdrb_bq_t e);
        host.fetch(pg, lim, stall);
        `CHK(host.saw_done, 1'b1)
        `CHK(host.got.size(), e.size())
        foreach (e[i]) if (i < host.got.size()) begin
            `CHK(host.got[i], e[i])
            `CHK(host.lst[i], 1'(i == e.size() - 1))
        end
    endtask
    // Reads one status flag, then clears all sticky flags for the next scenario.
    task automatic stat(input int b, input logic v);
        logic [31:0] d;
        rd(`VPDRB_ADDR_STAT, d);
        `CHK(d[b], v)
        wr(`VPDRB_ADDR_STAT, 32'h1f);
    endtask

    // ========================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] d;
        `CHK(req_ready, 1'b1)
        `CHK(out_valid, 1'b0)
        rd(`VPDRB_ADDR_TEXT, d);
        `CHK(d[6:0], `VPDRB_RST_TPAGE)
        @(posedge clk);
        #1 `CHK(reg_rdata, 32'h0)
        rd(8'h1c, d);
        `CHK(d, 32'h0)
    endtask
    task automatic t_text();
        vpdrb_bq_t t;
        vpdrb_bq_t e;
        t = '{8'h41, 8'h42, 8'h43, 8'h00, 8'h44, 8'h45, 8'h46, 8'h47, 8'h00, 8'h48, 8'h49,
              8'h00, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87};
        wr(`VPDRB_ADDR_UNIT, 32'h05);
        wr(`VPDRB_ADDR_TEXT, 32'h0008_0c12);
        load(`VPDRB_ADDR_TMEM, t);
        e = {8'h05, 8'h12, 8'h00, 8'h15, 8'h0c, t};
        page(8'h12, 16'd100, 40, e);
        stat(`VPDRB_STAT_TEXT, 1'b0);
        page(8'h12, 16'd5, 0, e[0:4]);
        wr(`VPDRB_ADDR_TMEM, 32'h017f);
        host.fetch(8'h12, 16'd100, 0);
        stat(`VPDRB_STAT_TEXT, 1'b1);
    endtask
    task automatic t_notext();
        logic [7:0] p[4] = '{8'h01, 8'h33, 8'h7f, 8'h12};
        wr(`VPDRB_ADDR_TEXT, 32'h0008_0012);
        foreach (p[i]) page(p[i], 16'd10, 0, '{8'h05, p[i], 8'h00, 8'h01, 8'h00});
    endtask
    task automatic t_refused();
        logic [7:0] p[4] = '{8'h00, 8'h80, 8'h84, 8'hff};
        foreach (p[i]) begin
            page(p[i], 16'd10, 0, none);
            stat(`VPDRB_STAT_REF, 1'b1);
        end
        page(8'h12, 16'h0000, 0, none);
    endtask
    task automatic t_id();
        logic [31:0] d;
        logic [7:0]  b0[4] = '{8'h00, 8'h02, 8'h02, 8'h02};
        logic [7:0]  b1[4] = '{8'h23, 8'h33, 8'h23, 8'h03};
        logic [3:0]  nm[4] = '{4'h1, 4'h1, 4'h2, 4'h1};
        logic        un[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
        int          sb[4] = '{1, 1, 3, 4};
        wr(`VPDRB_ADDR_ID, 32'h0106);
        load(`VPDRB_ADDR_IMEM, '{8'h02, 8'h23, 8'h00, 8'h02, 8'h58, 8'h59});
        page(8'h83, 16'd100, 0, '{8'h05, 8'h83, 8'h00, 8'h06, 8'h02, 8'h23, 8'h00, 8'h02,
             8'h58, 8'h59});
        rd(`VPDRB_ADDR_STAT, d);
        `CHK(d[4:0], 5'h0)
        page(8'h83, 16'd3, 0, '{8'h05, 8'h83, 8'h00});
        for (int k = 0; k < 4; k++) begin
            wr(`VPDRB_ADDR_IMEM, {24'h0, b0[k]});
            wr(`VPDRB_ADDR_IMEM, {16'h0, 8'h01, b1[k]});
            wr(`VPDRB_ADDR_ID, {20'h0, nm[k], 8'h06});
            wr(`VPDRB_ADDR_UNIT, {23'h0, un[k], 8'h05});
            host.fetch(8'h83, 16'd100, 0);
            stat(sb[k], 1'b1);
        end
    endtask
    task automatic t_fru();
        logic [31:0] d;
        logic [7:0]  c[5] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hff};
        foreach (c[i]) begin
            wr(`VPDRB_ADDR_FRU, {24'h0, c[i]});
            rd(`VPDRB_ADDR_FRU, d);
            `CHK(d[8:0], {(c[i] >= 8'h01 && c[i] <= 8'h7f), c[i]})
        end
    endtask

    // ========================================
    // Run control
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        reset = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fails = 0;
        n_checks = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        t_reset();
        t_text();
        t_notext();
        t_refused();
        t_id();
        t_fru();
        test_done();
    end
    // The whole run needs well under ten thousand cycles; this bound only catches a hang.
    initial begin
        #(40 * 60000);
        fails++;
        test_done();
    end
endmodule // vpd_page_response_builder_tb

// >>> tb/vpdrb_host.sv
`timescale 1ns/1ns
module vpdrb_host (
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   reset,
    // Request side.
    output logic                        req_valid,
    output vpdrb_pkg::vpdrb_req_t       req,
    input  wire logic                   req_ready,
    // Byte stream side.
    input  wire logic                   out_valid,
    input  wire vpdrb_pkg::vpdrb_byte_t out_byte,
    output logic                        out_ready,
    input  wire logic                   done
);
    import vpdrb_pkg::*;
    logic [7:0] got[$];
    logic       lst[$];
    logic       saw_done;

    initial begin
        req_valid = 1'b0;
        req       = '0;
        out_ready = 1'b0;
        saw_done  = 1'b0;
    end

    // ========================================
    // Requester and drain
    // A stall lets the block's buffer fill; odd cycles then keep it under back pressure.
    task automatic fetch(input logic [7:0] pg, input logic [15:0] lim, input int stall);
        int   n;
        logic fin;
        got.delete();
        lst.delete();
        saw_done = 1'b0;
        fin = 1'b0;
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{page: pg, host_buffer_limit: lim};
        @(posedge clk);
        req_valid <= 1'b0;
        for (n = 0; n < 3000 && !fin; n++) begin
            @(negedge clk);
            if (done === 1'b1) saw_done = 1'b1;
            if (out_valid === 1'b1 && out_ready === 1'b1) begin
                got.push_back(out_byte.data);
                lst.push_back(out_byte.last);
                fin = out_byte.last;
            end
            if (saw_done && got.size() == 0 && n > stall + 20) fin = 1'b1;
            @(posedge clk);
            out_ready <= !fin && n >= stall && (stall == 0 || n[0]);
        end
    endtask
endmodule // vpdrb_host
